// ---- common/aalu_regs.svh ----
// Constants for the accumulator datapath: widths, reset values, flag positions
`ifndef AALU_REGS_SVH
`define AALU_REGS_SVH

// ==========================================================
// Widths and depths
`define AALU_DATA_W      8
`define AALU_ADDR_W      6
`define AALU_DEPTH       64
`define AALU_BIT_W       3

// ==========================================================
// Reset values
`define AALU_WORK_RST    8'h00
`define AALU_FILE_RST    8'h00
`define AALU_FLAG_RST    1'b0

// ==========================================================
// Arithmetic positions
`define AALU_MSB         7
`define AALU_NIB_MSB     3
`define AALU_ZERO_BYTE   8'h00
`define AALU_ONE_HOT_B0  8'h01

// ==========================================================
// Flag positions inside the immediate of the flag load operation
`define AALU_FLG_C       0
`define AALU_FLG_HC      1
`define AALU_FLG_Z       2

`endif

// ---- common/aalu_pkg.sv ----
// Types shared by the accumulator datapath
`default_nettype none
package aalu_pkg;

  // ========================================================
  // Operation select presented with each instruction
  typedef enum logic [3:0] {
    AALU_OP_NOP       = 4'h0,
    AALU_OP_IMM_ADD_C = 4'h1,  // immediate_add_with_carry
    AALU_OP_IMM_ADD   = 4'h2,  // immediate_add
    AALU_OP_AND_REG   = 4'h3,  // and_with_register
    AALU_OP_AND_IMM   = 4'h4,  // and_with_immediate
    AALU_OP_BIT_CLR   = 4'h5,  // bit_clear_op
    AALU_OP_BIT_SET   = 4'h6,  // bit_set_op
    AALU_OP_LOAD_WORK = 4'h7,  // Immediate into working register
    AALU_OP_LOAD_FILE = 4'h8,  // Immediate into file register
    AALU_OP_LOAD_FLAG = 4'h9   // Immediate bits into flags
  } aalu_op_t;

endpackage : aalu_pkg
`default_nettype wire

// ---- hdl/aalu_file_regs.sv ----
// File register array of the accumulator datapath
`timescale 1ns/10ps
`default_nettype none
`include "aalu_regs.svh"

module aalu_file_regs (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      wr_en,
  input  wire logic [`AALU_ADDR_W-1:0]   wr_addr,
  input  wire logic [`AALU_DATA_W-1:0]   wr_data,
  input  wire logic [`AALU_ADDR_W-1:0]   rd_addr,
  output logic      [`AALU_DATA_W-1:0]   rd_data,
  input  wire logic [`AALU_ADDR_W-1:0]   obs_addr,
  output logic      [`AALU_DATA_W-1:0]   obs_data_ff
);

  // ========================================================
  // Storage
  logic [`AALU_DATA_W-1:0] mem_ff  [`AALU_DEPTH];
  logic [`AALU_DATA_W-1:0] nxt_mem [`AALU_DEPTH];
  logic [`AALU_DATA_W-1:0] nxt_obs_data;

  // ========================================================
  // One entry per generate step, written only when addressed
  genvar gi;
  generate
    for (gi = 0; gi < `AALU_DEPTH; gi = gi + 1) begin : g_entry
      always_comb begin
        nxt_mem[gi] = mem_ff[gi];
        if (wr_en && (wr_addr == `AALU_ADDR_W'(gi))) begin
          nxt_mem[gi] = wr_data;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_ff[gi] <= `AALU_FILE_RST;
        end else begin
          mem_ff[gi] <= nxt_mem[gi];
        end
      end
    end
  endgenerate

  // ========================================================
  // Operand read is combinational so one-cycle operations see it
  assign rd_data = mem_ff[rd_addr];

  // Observation read, registered
  always_comb begin
    nxt_obs_data = mem_ff[obs_addr];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      obs_data_ff <= `AALU_FILE_RST;
    end else begin
      obs_data_ff <= nxt_obs_data;
    end
  end

endmodule : aalu_file_regs
`default_nettype wire

// ---- hdl/aalu_core.sv ----
// Accumulator datapath: immediate adds, AND operations, bit set and bit clear
// Summary of operation
// - Immediate add with carry: working plus immediate plus carry; update Z, half carry, C.
// - Immediate add: working plus immediate, carry ignored; update Z, half carry, C.
// - AND with register: working AND file register 0..63; only Z changes.
// - Destination bit 0 writes working register; 1 writes back the file register.
// - AND with immediate: result into working register; only Z changes.
// - Bit clear: zero selected bit 0..7 of file register; others, flags kept.
// - Bit set: force selected bit 0..7 of file register; others, flags kept.
// - Carry set on carry out of bit 7, cleared otherwise.
`timescale 1ns/10ps
`default_nettype none
`include "aalu_regs.svh"

module aalu_core (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      op_valid,
  input  wire aalu_pkg::aalu_op_t        op_code,
  input  wire logic [`AALU_DATA_W-1:0]   op_imm,
  input  wire logic [`AALU_ADDR_W-1:0]   op_reg_addr,
  input  wire logic                      op_dest,
  input  wire logic [`AALU_BIT_W-1:0]    op_bit,
  input  wire logic [`AALU_ADDR_W-1:0]   obs_addr,
  output logic      [`AALU_DATA_W-1:0]   working_register,
  output logic                           zero_flag,
  output logic                           half_carry_flag,
  output logic                           carry_flag,
  output logic      [`AALU_DATA_W-1:0]   obs_data,
  output logic                           op_done
);

  // ========================================================
  // Declarations
  logic [`AALU_DATA_W-1:0] work_ff;
  logic [`AALU_DATA_W-1:0] nxt_work;
  logic                    zero_ff;
  logic                    nxt_zero;
  logic                    half_ff;
  logic                    nxt_half;
  logic                    carry_ff;
  logic                    nxt_carry;
  logic                    done_ff;
  logic                    nxt_done;

  logic                    file_we;
  logic [`AALU_DATA_W-1:0] file_wdata;
  logic [`AALU_DATA_W-1:0] file_rdata;

  logic                    add_cin;
  logic [`AALU_DATA_W:0]   add_sum;
  logic [`AALU_NIB_MSB+1:0] nib_sum;
  logic [`AALU_DATA_W-1:0] and_imm_res;
  logic [`AALU_DATA_W-1:0] and_reg_res;
  logic [`AALU_DATA_W-1:0] bit_mask;

  // ========================================================
  // File register array, operand read on the instruction address
  aalu_file_regs u_file_regs (
    .clk         (clk),
    .rst         (rst),
    .wr_en       (file_we),
    .wr_addr     (op_reg_addr),
    .wr_data     (file_wdata),
    .rd_addr     (op_reg_addr),
    .rd_data     (file_rdata),
    .obs_addr    (obs_addr),
    .obs_data_ff (obs_data)
  );

  // ========================================================
  // Adder shared by both immediate adds
  // Carry enters only for the carrying form
  assign add_cin = (op_code == aalu_pkg::AALU_OP_IMM_ADD_C) ? carry_ff : 1'b0;

  // Full sum with carry out of bit 7 in the top position
  assign add_sum = {1'b0, work_ff} + {1'b0, op_imm}
                 + {{`AALU_DATA_W{1'b0}}, add_cin};

  // Low nibble sum gives the half carry out of bit 3
  // Kept apart from the full sum so the carry-in reaches both the same way
  assign nib_sum = {1'b0, work_ff[`AALU_NIB_MSB:0]} + {1'b0, op_imm[`AALU_NIB_MSB:0]}
                 + {{(`AALU_NIB_MSB+1){1'b0}}, add_cin};

  // ========================================================
  // Logic results
  assign and_imm_res = work_ff & op_imm;
  assign and_reg_res = work_ff & file_rdata;

  // One-hot mask on the selected bit position
  assign bit_mask    = `AALU_ONE_HOT_B0 << op_bit;

  // ========================================================
  // Next state of working register and flags
  // Operations that only touch the file array leave all of these alone
  always_comb begin
    nxt_work  = work_ff;
    nxt_zero  = zero_ff;
    nxt_half  = half_ff;
    nxt_carry = carry_ff;
    if (op_valid) begin
      case (op_code)
        aalu_pkg::AALU_OP_IMM_ADD_C: begin
          // Sum includes the stored carry
          nxt_work  = add_sum[`AALU_DATA_W-1:0];
          nxt_zero  = (add_sum[`AALU_DATA_W-1:0] == `AALU_ZERO_BYTE);
          nxt_half  = nib_sum[`AALU_NIB_MSB+1];
          nxt_carry = add_sum[`AALU_DATA_W];
        end
        aalu_pkg::AALU_OP_IMM_ADD: begin
          // Sum without the stored carry
          nxt_work  = add_sum[`AALU_DATA_W-1:0];
          nxt_zero  = (add_sum[`AALU_DATA_W-1:0] == `AALU_ZERO_BYTE);
          nxt_half  = nib_sum[`AALU_NIB_MSB+1];
          nxt_carry = add_sum[`AALU_DATA_W];
        end
        aalu_pkg::AALU_OP_AND_REG: begin
          // Only the zero flag follows the result, wherever it goes
          nxt_zero = (and_reg_res == `AALU_ZERO_BYTE);
          if (!op_dest) begin
            nxt_work = and_reg_res;
          end
        end
        aalu_pkg::AALU_OP_AND_IMM: begin
          // Half carry and carry keep their values
          nxt_work = and_imm_res;
          nxt_zero = (and_imm_res == `AALU_ZERO_BYTE);
        end
        aalu_pkg::AALU_OP_LOAD_WORK: begin
          // Preload, flags untouched
          nxt_work = op_imm;
        end
        aalu_pkg::AALU_OP_LOAD_FLAG: begin
          // Preload of the three flags from fixed immediate bits
          nxt_carry = op_imm[`AALU_FLG_C];
          nxt_half  = op_imm[`AALU_FLG_HC];
          nxt_zero  = op_imm[`AALU_FLG_Z];
        end
        default: begin
          // Bit operations, file loads, no operation and unused codes
          nxt_work = work_ff;
        end
      endcase
    end
  end

  // ========================================================
  // File register write-back, taken at the same edge as the instruction
  // The old value is read combinationally so a bit operation takes one cycle
  always_comb begin
    file_we    = 1'b0;
    file_wdata = file_rdata;
    if (op_valid) begin
      case (op_code)
        aalu_pkg::AALU_OP_AND_REG: begin
          // Destination bit set sends the result back to the file register
          file_we    = op_dest;
          file_wdata = and_reg_res;
        end
        aalu_pkg::AALU_OP_BIT_CLR: begin
          // Read-modify-write of one bit, the other seven kept
          file_we    = 1'b1;
          file_wdata = file_rdata & ~bit_mask;
        end
        aalu_pkg::AALU_OP_BIT_SET: begin
          file_we    = 1'b1;
          file_wdata = file_rdata | bit_mask;
        end
        aalu_pkg::AALU_OP_LOAD_FILE: begin
          // Preload of the addressed entry
          file_we    = 1'b1;
          file_wdata = op_imm;
        end
        default: begin
          // Every other code leaves the array alone
          file_we    = 1'b0;
        end
      endcase
    end
  end

  // ========================================================
  // Working register and flags, updated at the edge that takes the instruction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      work_ff  <= `AALU_WORK_RST;
      zero_ff  <= `AALU_FLAG_RST;
      half_ff  <= `AALU_FLAG_RST;
      carry_ff <= `AALU_FLAG_RST;
    end else begin
      work_ff  <= nxt_work;
      zero_ff  <= nxt_zero;
      half_ff  <= nxt_half;
      carry_ff <= nxt_carry;
    end
  end

  // ========================================================
  // Completion pulse, raised for every accepted code including unused ones
  always_comb begin
    nxt_done = op_valid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_ff <= `AALU_FLAG_RST;
    end else begin
      done_ff <= nxt_done;
    end
  end

  // ========================================================
  // Outputs straight from flip-flops
  // Nothing here is combinational, so they may be sampled just after the edge
  assign working_register = work_ff;
  assign zero_flag        = zero_ff;
  assign half_carry_flag  = half_ff;
  assign carry_flag       = carry_ff;
  assign op_done          = done_ff;

endmodule : aalu_core
`default_nettype wire

// ---- verification/aalu_core_props.sv ----
// Port-level concurrent checks for the accumulator datapath
`timescale 1ns/10ps
`default_nettype none

module aalu_core_props (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               op_valid,
  input wire aalu_pkg::aalu_op_t op_code,
  input wire logic [7:0]         op_imm,
  input wire logic [5:0]         op_reg_addr,
  input wire logic               op_dest,
  input wire logic [2:0]         op_bit,
  input wire logic [5:0]         obs_addr,
  input wire logic [7:0]         working_register,
  input wire logic               zero_flag,
  input wire logic               half_carry_flag,
  input wire logic               carry_flag,
  input wire logic [7:0]         obs_data,
  input wire logic               op_done
);
  default clocking dck @(posedge clk); endclocking
  default disable iff (rst);
  logic add_c;
  logic add_n;
  logic and_i;
  logic and_r;
  logic bit_op;

  // ==========================================================
  // Decoded operation strobes
  assign add_c  = op_valid && op_code == aalu_pkg::AALU_OP_IMM_ADD_C;
  assign add_n  = op_valid && op_code == aalu_pkg::AALU_OP_IMM_ADD;
  assign and_i  = op_valid && op_code == aalu_pkg::AALU_OP_AND_IMM;
  assign and_r  = op_valid && op_code == aalu_pkg::AALU_OP_AND_REG;
  assign bit_op = op_valid && (op_code == aalu_pkg::AALU_OP_BIT_CLR ||
                               op_code == aalu_pkg::AALU_OP_BIT_SET);

  // Nine-bit sums: carry out of bit 7 lands in the carry flag
  add_carry_a: assert property (add_c |=> {carry_flag, working_register} ==
    $past(working_register) + $past(op_imm) + $past(carry_flag)) else $error("adc sum wrong");
  add_plain_a: assert property (add_n |=> {carry_flag, working_register} ==
    $past(working_register) + $past(op_imm)) else $error("add sum wrong");
  half_carry_a: assert property (add_n |=> half_carry_flag ==
    (5'($past(working_register[3:0])) + $past(op_imm[3:0]) > 5'h0f)) else $error("half carry wrong");
  carry_half_a: assert property (add_c |=> half_carry_flag ==
    (5'($past(working_register[3:0])) + $past(op_imm[3:0]) + $past(carry_flag) > 5'h0f))
    else $error("half carry with carry-in wrong");
  add_zero_a: assert property ((add_c || add_n) |=> zero_flag == (working_register == 8'h00))
    else $error("add zero flag wrong");
  // AND results and the flags they leave alone
  and_imm_a: assert property (and_i |=> working_register ==
    ($past(working_register) & $past(op_imm)) && zero_flag == (working_register == 8'h00))
    else $error("and immediate wrong");
  and_flags_a: assert property ((and_i || and_r) |=> $stable(carry_flag) &&
    $stable(half_carry_flag)) else $error("and touched half carry or carry");
  and_dest_a: assert property (and_r && op_dest |=> $stable(working_register))
    else $error("file destination changed working register");
  bit_keep_a: assert property (bit_op |=> $stable({working_register, zero_flag,
    half_carry_flag, carry_flag})) else $error("bit op changed state");
  // One-cycle completion
  done_pulse_a: assert property (op_valid |=> op_done) else $error("no done");
  idle_keep_a: assert property (!op_valid |=> !op_done && $stable(working_register))
    else $error("idle cycle changed state");
endmodule : aalu_core_props

`default_nettype wire

// ---- verification/aalu_core_tb_top.sv ----
// Self-checking bench for the accumulator datapath
`timescale 1ns/10ps
`default_nettype none

module aalu_core_tb_top;
  logic               clk;
  logic               rst;
  logic               op_valid;
  aalu_pkg::aalu_op_t op_code;
  logic [7:0]         op_imm;
  logic [5:0]         op_reg_addr;
  logic               op_dest;
  logic [2:0]         op_bit;
  logic [5:0]         obs_addr;
  logic [7:0]         working_register;
  logic               zero_flag;
  logic               half_carry_flag;
  logic               carry_flag;
  logic [7:0]         obs_data;
  logic               op_done;
  int                 error_cnt;
  int                 n_tests;
  // ==========================================================
  // Rows: op imm addr dest bit working flags(z,dc,c) file
  localparam logic [47:0] rows [23] = '{
    48'h7120_0001_2000, 48'h9010_0001_2100, 48'h1340_0004_7000, 48'h7120_0001_2000,
    48'h9010_0001_2100, 48'h2340_0004_6000, 48'h1BA0_0000_0700, 48'h1FF0_0000_0700,
    48'h75A0_0005_A700, 48'h4AF0_0000_A300, 48'h4000_0000_0700, 48'h8AF3_F000_07AF,
    48'h75A3_F005_A7AF, 48'h3003_F105_A30A, 48'h3003_F000_A30A, 48'h85A0_0000_A35A,
    48'h5000_0030_A352, 48'h6000_0020_A356, 48'h6000_0070_A3D6, 48'h5000_0010_A3D4,
    48'h6000_0000_A3D5, 48'h0FF0_0000_A3D5, 48'hFFF0_0000_A3D5};

  aalu_core i_dut (.clk, .rst, .op_valid, .op_code, .op_imm, .op_reg_addr, .op_dest,
    .op_bit, .obs_addr, .working_register, .zero_flag, .half_carry_flag, .carry_flag,
    .obs_data, .op_done);

  // Compare one value and count it
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : check

  // Present one instruction just after an edge, return just after the taking edge
  task automatic drive(input logic [3:0] op, input logic [7:0] imm, input logic [5:0] adr,
                       input logic dst, input logic [2:0] bp, input logic vld);
    op_code     = aalu_pkg::aalu_op_t'(op);
    op_imm      = imm;
    op_reg_addr = adr;
    obs_addr    = adr;
    op_dest     = dst;
    op_bit      = bp;
    op_valid    = vld;
    @(posedge clk);
    #1;
  endtask : drive

  // Counts, verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // Core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    error_cnt = 0;
    n_tests   = 0;
    rst       = 1'b1;
    drive(4'h0, 8'h00, 6'h00, 1'b0, 3'h0, 1'b0);
    repeat (19) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 23; i++) begin
      drive(rows[i][47:44], rows[i][43:36], rows[i][33:28], rows[i][24], rows[i][22:20], 1'b1);
      check("working", rows[i][19:12], working_register);
      check("flags", {5'h0, rows[i][10:8]}, {5'h0, zero_flag, half_carry_flag, carry_flag});
      check("done", 8'h01, {7'h0, op_done});
      drive(4'h0, 8'h00, rows[i][33:28], 1'b0, 3'h0, 1'b0);
      check("file", rows[i][7:0], obs_data);
    end
    $display("row tests ended");
    // Back to back adds, each seeing the previous sum
    drive(4'h7, 8'hFE, 6'h00, 1'b0, 3'h0, 1'b1);
    drive(4'h2, 8'h01, 6'h00, 1'b0, 3'h0, 1'b1);
    drive(4'h2, 8'h01, 6'h00, 1'b0, 3'h0, 1'b1);
    check("chain working", 8'h00, working_register);
    check("chain flags", 8'h07, {5'h0, zero_flag, half_carry_flag, carry_flag});
    check("chain done", 8'h01, {7'h0, op_done});
    drive(4'h2, 8'h55, 6'h00, 1'b0, 3'h0, 1'b0);
    check("idle working", 8'h00, working_register);
    check("idle done", 8'h00, {7'h0, op_done});
    $display("back to back test ended");
    // Reset in mid-run clears state and file array; nonzero state is left first
    drive(4'h7, 8'hA5, 6'h3F, 1'b0, 3'h0, 1'b1);
    rst = 1'b1;
    #1;
    check("reset working", 8'h00, working_register);
    check("reset flags", 8'h00, {5'h0, zero_flag, half_carry_flag, carry_flag});
    check("reset done", 8'h00, {7'h0, op_done});
    check("reset obs", 8'h00, obs_data);
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    drive(4'h0, 8'h00, 6'h3F, 1'b0, 3'h0, 1'b0);
    drive(4'h0, 8'h00, 6'h3F, 1'b0, 3'h0, 1'b0);
    check("reset file", 8'h00, obs_data);
    drive(4'h1, 8'h01, 6'h00, 1'b0, 3'h0, 1'b1);
    check("reset carry add", 8'h01, working_register);
    $display("reset test ended");
    complete_run();
  end
endmodule : aalu_core_tb_top

bind aalu_core aalu_core_props i_props (.clk, .rst, .op_valid, .op_code, .op_imm,
  .op_reg_addr, .op_dest, .op_bit, .obs_addr, .working_register, .zero_flag,
  .half_carry_flag, .carry_flag, .obs_data, .op_done);

`default_nettype wire
